//--- aec_consts.vh
`ifndef AEC_CONSTS_VH
`define AEC_CONSTS_VH

// register indices; byte address is four times the index
`define AEC_IDX_EDGE     16'hff92
`define AEC_IDX_CLKSEL   16'hff94
`define AEC_IDX_CTRL     16'hff95
`define AEC_IDX_COUNT    16'hff97
`define AEC_IDX_IRQFLAG  16'hff98
`define AEC_IDX_IRQEN    16'hff99
`define AEC_IDX_PRESC    16'hff9a
`define AEC_AW           18

// field positions
`define AEC_EDGE_HI      5
`define AEC_EDGE_LO      4
`define AEC_PWM_EN       1
`define AEC_CKSEL_HI     5
`define AEC_CKSEL_LO     4
`define AEC_OVL          6
`define AEC_CH2          4
`define AEC_COUNT_UP_ENABLE_LOW         2
`define AEC_COUNTER_RESET_CTRL_LOW         0
`define AEC_IRQ_BIT      0

// encodings and reset values
`define AEC_CKSEL_PIN    2'b00
`define AEC_EDGE_FALL    2'b00
`define AEC_EDGE_RISE    2'b01
`define AEC_COUNT_MAX    8'hff
`define AEC_COUNT_ZERO   8'h00
`define AEC_RST_BYTE     8'h00
`define AEC_PRESC_W      13
`define AEC_HTRANS_NSEQ  1

`endif

//--- aec_edge_sync.v
`timescale 1ns/10ps
`default_nettype none
`include "aec_consts.vh"

module aec_edge_sync (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       pin,
	input  wire [1:0] edge_sel,
	output reg        pulse
);
	reg sync1_q;
	reg sync2_q;
	reg last_q;

	////////////////////////////////////////////////////////////////////////
	// two-flop synchroniser, then one more stage for the edge compare
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			last_q  <= 1'b1;
		end else begin
			sync1_q <= pin;
			sync2_q <= sync1_q; // only this flop reads the first stage
			last_q  <= sync2_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// edge selection; pin pulses shorter than one clock may be missed
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse <= 1'b0;
		end else begin
			case (edge_sel)
			`AEC_EDGE_FALL: pulse <= last_q & ~sync2_q;
			`AEC_EDGE_RISE: pulse <= ~last_q & sync2_q;
			default:        pulse <= last_q ^ sync2_q;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- aec_prescaler.v
`timescale 1ns/10ps
`default_nettype none
`include "aec_consts.vh"

module aec_prescaler #(
	parameter WIDTH = `AEC_PRESC_W
) (
	input  wire             clk,
	input  wire             rst_n,
	output reg  [WIDTH-1:0] count
);
	// free running, wraps silently
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= {WIDTH{1'b0}};
		end else begin
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule
`default_nettype wire

//--- aec_counter.v
// Register access over AHB-Lite was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "aec_consts.vh"

module aec_counter (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg  [31:0] hrdata,
	output reg         hresp,
	input  wire        async_event_pin_low,
	input  wire        event_enable_pin,
	output reg         irq
);
	localparam NREG = 7;
	localparam R_EDGE = 0;
	localparam R_CLK  = 1;
	localparam R_CTRL = 2;
	localparam R_CNT  = 3;
	localparam R_IFLG = 4;
	localparam R_IEN  = 5;
	localparam R_PRE  = 6;

	// one-hot register select from a byte address
	function [NREG-1:0] dec;
		input [`AEC_AW-1:0] a;
		begin
			dec = {NREG{1'b0}};
			dec[R_EDGE] = (a == {`AEC_IDX_EDGE, 2'b00});
			dec[R_CLK]  = (a == {`AEC_IDX_CLKSEL, 2'b00});
			dec[R_CTRL] = (a == {`AEC_IDX_CTRL, 2'b00});
			dec[R_CNT]  = (a == {`AEC_IDX_COUNT, 2'b00});
			dec[R_IFLG] = (a == {`AEC_IDX_IRQFLAG, 2'b00});
			dec[R_IEN]  = (a == {`AEC_IDX_IRQEN, 2'b00});
			dec[R_PRE]  = (a == {`AEC_IDX_PRESC, 2'b00});
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// bus state
	reg  [NREG-1:0] wsel_q;
	reg             wr_q;
	wire            aphase;
	wire [NREG-1:0] asel;
	wire [NREG-1:0] wstb;

	// control and status
	reg  [1:0] edge_sel_q;
	reg        counter_pwm_enable_q;
	reg  [1:0] clk_sel_q;
	reg        overflow_flag_low_q;
	reg        ovl_d;
	reg        ovl_seen_q;
	reg        ovl_seen_d;
	reg        channel_split_select_q;
	reg        count_up_enable_low_q;
	reg        counter_reset_ctrl_low_q;
	reg  [7:0] event_count_low_q;
	reg  [7:0] count_d;
	reg        counter_irq_flag_q;
	reg        iflag_d;
	reg        counter_irq_enable_q;
	reg  [7:0] edge_d;
	reg  [7:0] clk_d;
	reg  [7:0] ctrl_d;
	reg  [31:0] rdata_d;

	wire [`AEC_PRESC_W-1:0] system_prescaler;
	wire                    ev_pulse;
	wire                    step;
	wire                    ovf;

	aec_prescaler #(
		.WIDTH (`AEC_PRESC_W)
	) u_presc (
		.clk   (hclk),
		.rst_n (hresetn),
		.count (system_prescaler)
	);

	aec_edge_sync u_sync (
		.clk      (hclk),
		.rst_n    (hresetn),
		.pin      (async_event_pin_low),
		.edge_sel (edge_sel_q),
		.pulse    (ev_pulse)
	);

	////////////////////////////////////////////////////////////////////////
	// address phase decode; zero wait states so hready is always ours
	assign aphase = hsel & htrans[`AEC_HTRANS_NSEQ] & hready;
	assign asel   = dec(haddr[`AEC_AW-1:0]);
	assign wstb   = wr_q ? wsel_q : {NREG{1'b0}};

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wsel_q    <= {NREG{1'b0}};
			wr_q      <= 1'b0;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			wsel_q    <= aphase ? asel : {NREG{1'b0}};
			wr_q      <= aphase & hwrite;
			hreadyout <= 1'b1;
			hresp     <= 1'b0; // always okay, unmapped included
		end
	end

	////////////////////////////////////////////////////////////////////////
	// counting gate: the pin only qualifies when pwm is off
	assign step = ev_pulse
		& (clk_sel_q == `AEC_CKSEL_PIN)
		& channel_split_select_q
		& count_up_enable_low_q
		& counter_reset_ctrl_low_q
		& ~counter_pwm_enable_q
		& event_enable_pin;
	assign ovf = step & (event_count_low_q == `AEC_COUNT_MAX) & ~wstb[R_CNT];

	////////////////////////////////////////////////////////////////////////
	// next values of everything software touches except the irq enable
	always @* begin
		edge_d = {2'b00, edge_sel_q, 2'b00, counter_pwm_enable_q, 1'b0};
		clk_d  = {2'b00, clk_sel_q, 4'h0};
		if (wstb[R_EDGE]) begin
			edge_d = `AEC_RST_BYTE;
			edge_d[`AEC_EDGE_HI] = hwdata[`AEC_EDGE_HI];
			edge_d[`AEC_EDGE_LO] = hwdata[`AEC_EDGE_LO];
			edge_d[`AEC_PWM_EN]  = hwdata[`AEC_PWM_EN];
		end
		if (wstb[R_CLK]) begin
			clk_d = `AEC_RST_BYTE;
			clk_d[`AEC_CKSEL_HI] = hwdata[`AEC_CKSEL_HI];
			clk_d[`AEC_CKSEL_LO] = hwdata[`AEC_CKSEL_LO];
		end
		ctrl_d = `AEC_RST_BYTE;
		ctrl_d[`AEC_CH2]  = wstb[R_CTRL] ? hwdata[`AEC_CH2] : channel_split_select_q;
		ctrl_d[`AEC_COUNT_UP_ENABLE_LOW] = wstb[R_CTRL] ? hwdata[`AEC_COUNT_UP_ENABLE_LOW] : count_up_enable_low_q;
		ctrl_d[`AEC_COUNTER_RESET_CTRL_LOW] = wstb[R_CTRL] ? hwdata[`AEC_COUNTER_RESET_CTRL_LOW] : counter_reset_ctrl_low_q;
		// overflow: set wins over a clear in the same cycle
		ovl_d      = overflow_flag_low_q;
		ovl_seen_d = ovl_seen_q;
		if (aphase & ~hwrite & asel[R_CTRL] & overflow_flag_low_q) begin
			ovl_seen_d = 1'b1;
		end
		if (wstb[R_CTRL] & ~hwdata[`AEC_OVL] & ovl_seen_q) begin
			ovl_d      = 1'b0;
			ovl_seen_d = 1'b0;
		end
		if (ovf & channel_split_select_q) begin
			ovl_d = 1'b1;
		end
		ctrl_d[`AEC_OVL] = ovl_d;
		// request flag: writing 0 clears, writing 1 does nothing
		iflag_d = counter_irq_flag_q;
		if (wstb[R_IFLG] & ~hwdata[`AEC_IRQ_BIT]) begin
			iflag_d = 1'b0;
		end
		if (ovf) begin
			iflag_d = 1'b1;
		end
		// counter: held clear by reset control, software clear on any write
		count_d = event_count_low_q;
		if (~ctrl_d[`AEC_COUNTER_RESET_CTRL_LOW]) begin
			count_d = `AEC_COUNT_ZERO;
		end else if (wstb[R_CNT]) begin
			count_d = `AEC_COUNT_ZERO;
		end else if (step) begin
			count_d = event_count_low_q + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			edge_sel_q               <= 2'b00;
			counter_pwm_enable_q     <= 1'b0;
			clk_sel_q                <= 2'b00;
			overflow_flag_low_q      <= 1'b0;
			ovl_seen_q               <= 1'b0;
			channel_split_select_q   <= 1'b0;
			count_up_enable_low_q    <= 1'b0;
			counter_reset_ctrl_low_q <= 1'b0;
			event_count_low_q        <= `AEC_COUNT_ZERO;
			counter_irq_flag_q       <= 1'b0;
			counter_irq_enable_q     <= 1'b0;
		end else begin
			edge_sel_q               <= edge_d[`AEC_EDGE_HI:`AEC_EDGE_LO];
			counter_pwm_enable_q     <= edge_d[`AEC_PWM_EN];
			clk_sel_q                <= clk_d[`AEC_CKSEL_HI:`AEC_CKSEL_LO];
			overflow_flag_low_q      <= ovl_d;
			ovl_seen_q               <= ovl_seen_d;
			channel_split_select_q   <= ctrl_d[`AEC_CH2];
			count_up_enable_low_q    <= ctrl_d[`AEC_COUNT_UP_ENABLE_LOW];
			counter_reset_ctrl_low_q <= ctrl_d[`AEC_COUNTER_RESET_CTRL_LOW];
			event_count_low_q        <= count_d;
			counter_irq_flag_q       <= iflag_d;
			if (wstb[R_IEN]) begin
				counter_irq_enable_q <= hwdata[`AEC_IRQ_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux works from next values so a read right after a write sees it
	always @* begin
		rdata_d = 32'h0000_0000;
		case (1'b1)
		asel[R_EDGE]: rdata_d[7:0] = edge_d;
		asel[R_CLK]:  rdata_d[7:0] = clk_d;
		asel[R_CTRL]: rdata_d[7:0] = ctrl_d;
		asel[R_CNT]:  rdata_d[7:0] = count_d;
		asel[R_IFLG]: rdata_d[`AEC_IRQ_BIT] = iflag_d;
		asel[R_IEN]:  rdata_d[`AEC_IRQ_BIT] = wstb[R_IEN] ? hwdata[`AEC_IRQ_BIT] : counter_irq_enable_q;
		asel[R_PRE]:  rdata_d[`AEC_PRESC_W-1:0] = system_prescaler;
		default:      rdata_d = 32'h0000_0000;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (aphase & ~hwrite) begin
			hrdata <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// level interrupt, gated by the enable; one flop late by design
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= counter_irq_flag_q & counter_irq_enable_q;
		end
	end
endmodule
`default_nettype wire

//--- aec_counter_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "aec_consts.vh"
module aec_checker (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	input wire logic        async_event_pin_low,
	input wire logic        event_enable_pin,
	input wire logic        irq
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic        tk;
	logic        wr_dp_q;
	logic        en_sh_q;
	logic        pin_q;
	logic [15:0] wa_q;
	logic [3:0]  ev_age_q;
	logic [3:0]  wr_age_q;
	assign tk = hsel && htrans[1] && hready;
	// shadow of the enable bit and ages of the last pin change and write
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_dp_q <= 1'b0;
			wa_q <= 16'h0000;
			en_sh_q <= 1'b0;
			pin_q <= 1'b1;
			ev_age_q <= 4'hf;
			wr_age_q <= 4'hf;
		end else begin
			wr_dp_q <= tk && hwrite;
			wa_q <= haddr[17:2];
			if (wr_dp_q && wa_q == `AEC_IDX_IRQEN)
				en_sh_q <= hwdata[0];
			pin_q <= async_event_pin_low;
			ev_age_q <= (async_event_pin_low != pin_q) ? 4'h0 : ev_age_q + {3'h0, ev_age_q != 4'hf};
			wr_age_q <= wr_dp_q ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hf};
		end
	end
	////////////////////////////////
	sequence s_rdp;
		tk && !hwrite && haddr[17:2] == `AEC_IDX_PRESC;
	endsequence
	// two reads two cycles apart must see the prescaler two steps on
	property p_step;
		s_rdp ##2 s_rdp |=> ((hrdata - $past(hrdata, 2)) & 32'h00001fff) == 32'h00000002;
	endproperty
	AST_OKAY: assert property (!hresp) else $error("error response");
	AST_READY: assert property ($past(hresetn) |-> hreadyout) else $error("wait state");
	AST_PRESC_STEP: assert property (p_step) else $error("prescaler step");
	AST_COUNT_WIDTH: assert property (tk && !hwrite && haddr[17:2] == `AEC_IDX_COUNT
		|=> hrdata[31:8] == 24'h000000) else $error("counter wider than a byte");
	AST_IRQEN_RB: assert property (tk && !hwrite && haddr[17:2] == `AEC_IDX_IRQEN
		|=> hrdata == {31'h0, en_sh_q}) else $error("enable readback");
	AST_IRQ_MASK: assert property (irq |-> en_sh_q || $past(en_sh_q)) else $error("irq while masked");
	AST_IRQ_RISE: assert property ($rose(irq) |-> ev_age_q <= 4'ha || wr_age_q <= 4'h4)
		else $error("irq without cause");
	AST_IRQ_FALL: assert property ($fell(irq) |-> wr_age_q <= 4'h4) else $error("irq dropped alone");
endmodule
bind aec_counter aec_checker i_aec_checker (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
	.hwdata, .hready, .hreadyout, .hrdata, .hresp, .async_event_pin_low, .event_enable_pin, .irq);
`default_nettype wire

//--- aec_event_src.sv
`timescale 1ns/10ps
`default_nettype none
module aec_event_src (
	input wire logic       hclk,
	input wire logic       go,
	input wire logic [8:0] n,
	input wire logic [2:0] hw,
	output logic           pin,
	output logic           busy
);
	// n falling edges, each level held hw cycles; line rests high between bursts
	initial begin
		pin = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge hclk);
			if (go) begin
				busy <= 1'b1;
				repeat (n) begin
					repeat (hw) @(posedge hclk);
					pin <= 1'b0;
					repeat (hw) @(posedge hclk);
					pin <= 1'b1;
				end
				busy <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- async_event_counter_8bit_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "aec_consts.vh"
module async_event_counter_8bit_bench;
	logic        hclk, hresetn, hsel, hwrite, go, en_pin, pin, busy, irq, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize, hw;
	logic [31:0] haddr, hwdata, hrdata, r, p;
	logic [8:0]  n, k;
	logic [7:0]  c;
	logic [15:0] ix [6];
	int          miscompares, n_checks, cyc, i;
	aec_counter i_aec_counter (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp, .async_event_pin_low(pin),
		.event_enable_pin(en_pin), .irq);
	aec_event_src i_aec_event_src (.hclk, .go, .n, .hw, .pin, .busy);
	always #10 hclk = ~hclk;
	// hang guard
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares++;
			test_done();
		end
	end
	////////////////////////////////
	task automatic test_done();
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one single word transfer; read data lands in r
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {14'h0, a, 2'b00};
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		r = hrdata;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		cmp(r, e);
	endtask
	// irq follows its flag one cycle late, so two edges pass first
	task automatic chk_irq(input logic [31:0] e);
		repeat (2) @(posedge hclk);
		cmp({31'h0, irq}, e);
	endtask
	// a burst of m edges at a random pace; then let the synchroniser drain
	task automatic pulses(input logic [8:0] m);
		n <= m;
		hw <= 3'(2 + $urandom % 3);
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		@(posedge hclk);
		while (busy) @(posedge hclk);
		repeat (8) @(posedge hclk);
	endtask
	function automatic logic [31:0] ecnt(input logic [7:0] s, input logic [8:0] m, input logic open);
		return {24'h0, open ? s + m[7:0] : s};
	endfunction
	////////////////////////////////
	initial begin
		hclk = 0; hresetn = 0; hsel = 0; htrans = 0; hwrite = 0; hsize = 3'b010;
		haddr = 0; hwdata = 0; go = 0; n = 0; hw = 3'd2; en_pin = 1'b1;
		miscompares = 0; n_checks = 0; cyc = 0;
		ix = '{`AEC_IDX_EDGE, `AEC_IDX_CLKSEL, `AEC_IDX_CTRL, `AEC_IDX_COUNT, `AEC_IDX_IRQFLAG, `AEC_IDX_IRQEN};
		p = $urandom(49660);
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (i = 0; i < 6; i++)
			rd(ix[i], 32'h0);
		bus(1'b0, `AEC_IDX_PRESC, 32'h0);
		p = r;
		bus(1'b0, `AEC_IDX_PRESC, 32'h0);
		cmp((r - p) & 32'h00001fff, 32'h2);
		bus(1'b1, `AEC_IDX_IRQEN, 32'h1);
		bus(1'b1, `AEC_IDX_CTRL, 32'h14);
		pulses(9'd5);
		rd(`AEC_IDX_COUNT, 32'h0);
		// each pass closes one gate; first and last leave all open
		for (i = 0; i < 6; i++) begin
			en_pin <= (i != 1);
			bus(1'b1, `AEC_IDX_CLKSEL, (i == 2) ? 32'h10 : 32'h0);
			bus(1'b1, `AEC_IDX_EDGE, (i == 3) ? 32'h2 : 32'h0);
			bus(1'b1, `AEC_IDX_CTRL, (i == 4) ? 32'h11 : 32'h15);
			bus(1'b0, `AEC_IDX_COUNT, 32'h0);
			c = r[7:0];
			k = 9'(1 + $urandom % 40);
			pulses(k);
			rd(`AEC_IDX_COUNT, ecnt(c, k, i == 0 || i == 5));
		end
		// rising edges count once per pulse, both edges twice; pin rests high so no false edge
		for (i = 1; i < 3; i++) begin
			bus(1'b1, `AEC_IDX_EDGE, 32'(i << 4));
			bus(1'b0, `AEC_IDX_COUNT, 32'h0);
			c = r[7:0];
			k = 9'(1 + $urandom % 40);
			pulses(k);
			rd(`AEC_IDX_COUNT, ecnt(c, 9'(k * i), 1'b1));
		end
		bus(1'b1, `AEC_IDX_EDGE, 32'h0);
		bus(1'b1, `AEC_IDX_COUNT, 32'h0);
		rd(`AEC_IDX_COUNT, 32'h0);
		pulses(9'd256);
		rd(`AEC_IDX_COUNT, 32'h0);
		chk_irq(32'h1);
		rd(`AEC_IDX_IRQFLAG, 32'h1);
		// no read before this write, then a write of one: flag must survive both
		bus(1'b1, `AEC_IDX_CTRL, 32'h15);
		bus(1'b1, `AEC_IDX_CTRL, 32'h55);
		rd(`AEC_IDX_CTRL, 32'h55);
		bus(1'b1, `AEC_IDX_CTRL, 32'h15);
		rd(`AEC_IDX_CTRL, 32'h15);
		bus(1'b1, `AEC_IDX_IRQEN, 32'h0);
		chk_irq(32'h0);
		bus(1'b1, `AEC_IDX_IRQEN, 32'h1);
		chk_irq(32'h1);
		bus(1'b1, `AEC_IDX_IRQFLAG, 32'h1);
		chk_irq(32'h1);
		bus(1'b1, `AEC_IDX_IRQFLAG, 32'h0);
		chk_irq(32'h0);
		test_done();
	end
endmodule
`default_nettype wire
